// ===== design/sfpc_params.svh
// Constants for the synthesizer frequency and power amplifier control block.
// Assumes inclusion by the package and the testbench; defines only.
`ifndef SFPC_PARAMS_SVH
`define SFPC_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define SFPC_A_BASE_HI   8'h00
`define SFPC_A_BASE_MID  8'h04
`define SFPC_A_BASE_LO   8'h08
`define SFPC_A_HOP       8'h0C
`define SFPC_A_MODEM_LO  8'h10
`define SFPC_A_MODEM_HI  8'h14
`define SFPC_A_SYNTH1    8'h18
`define SFPC_A_STATE0    8'h1C
`define SFPC_A_FRONT0    8'h20
`define SFPC_A_CMD       8'h24
`define SFPC_A_STATUS    8'h28
`define SFPC_A_CARRIER   8'h2C
`define SFPC_PTAB_HI3    3'h2
// ==========================================================
// Field positions and encodings
`define SFPC_CMD_CAL_BIT 0
`define SFPC_ACAL_MANUAL 2'h0
`define SFPC_ACAL_ON     2'h1
`define SFPC_ACAL_OFF    2'h2
`define SFPC_RESP_OKAY   2'h0
`define SFPC_RESP_SLVERR 2'h2
// ==========================================================
// Reset values
`define SFPC_RST_BYTE    8'h00
`define SFPC_RST_EXP     2'h2
`define SFPC_RST_IF      5'h0F
`define SFPC_RST_ACAL    2'h1
`define SFPC_RST_TOP     3'h0
`define SFPC_RST_PTAB    8'hC6
// ==========================================================
// Timing: calibration length in crystal periods, one sys_clk each
`define SFPC_CAL_PERIODS 18739
`define SFPC_CAL_CNT_W   15
`endif

// ===== design/sfpc_pkg.sv
// Types for the synthesizer frequency and power amplifier control block.
// Assumes sfpc_params.svh is on the include path.
package sfpc_pkg;
`include "sfpc_params.svh"
	// ==========================================================
	// Calibration sequencer
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN  = 2'b01
	} sfpc_cal_e;
	// ==========================================================
	// Radio side carriers
	typedef struct packed {
		logic radio_idle;
		logic synth_on;
		logic tx_active;
		logic ask_mode;
		logic ask_bit;
		logic shape_tick;
	} sfpc_radio_s;
	typedef struct packed {
		logic [26:0] carrier_word;
		logic [4:0]  if_word;
		logic        cal_busy;
		logic        cal_valid;
		logic        cal_done;
	} sfpc_synth_s;
	typedef struct packed {
		logic [2:0] pa_index;
		logic [7:0] pa_setting;
	} sfpc_pa_s;
	// ==========================================================
	// Whole block state
	typedef struct packed {
		logic [7:0]                   f_hi;
		logic [7:0]                   f_mid;
		logic [7:0]                   f_lo;
		logic [7:0]                   hop_index;
		logic [7:0]                   spacing_mantissa;
		logic [1:0]                   spacing_exponent;
		logic [4:0]                   if_tuning;
		logic [1:0]                   acal;
		logic [2:0]                   top;
		logic [7:0][7:0]              ptab;
		sfpc_cal_e                    cal;
		logic [`SFPC_CAL_CNT_W-1:0]   cal_cnt;
		logic                         cal_valid;
		logic                         cal_done;
		logic                         synth_on;
		logic [2:0]                   shp;
		logic [7:0]                   pa_set;
		logic [26:0]                  carrier;
		logic                         aw_h;
		logic                         w_h;
		logic [7:0]                   awa;
		logic [7:0]                   wd;
		logic                         wst;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
	} sfpc_state_s;
endpackage : sfpc_pkg

// ===== design/sfpc_ctrl.sv
// Synthesizer frequency word, calibration sequencer and Power_table_top_index shaping.
// Assumes radio inputs come from logic on sys_clk and sys_clk is the crystal clock.
module sfpc_ctrl import sfpc_pkg::*; #(
	parameter int ADDR_W     = 8,
	parameter int CAL_CYCLES = `SFPC_CAL_PERIODS
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire sfpc_radio_s       radio,
	output sfpc_synth_s            synth,
	output sfpc_pa_s               pa
);
	// ==========================================================
	// Arithmetic
	// Spacing scaled by four so exponents 0 and 1 stay exact
	function automatic logic [26:0] calc_carrier(
		input logic [23:0] f,
		input logic [7:0]  ch,
		input logic [7:0]  m,
		input logic [1:0]  e
	);
		logic [11:0] sp;
		sp = (12'(m) << e) + 12'h400;
		return 27'({f, 2'b00}) + 27'(20'(ch) * 20'(sp));
	endfunction : calc_carrier

	localparam logic [`SFPC_CAL_CNT_W-1:0] CAL_LAST = `SFPC_CAL_CNT_W'(CAL_CYCLES - 1);

	sfpc_state_s s_q;
	sfpc_state_s s_d;
	logic        wr_go;
	logic        cal_cmd;
	logic        son_rise;
	logic        son_fall;
	logic        auto_trig;
	logic        man_trig;
	logic        up;
	logic [7:0]  ra;

	assign s_axi_awready = !s_q.aw_h && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_h && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	assign synth.carrier_word = s_q.carrier;
	assign synth.if_word      = s_q.if_tuning;
	assign synth.cal_busy     = (s_q.cal == CAL_RUN);
	assign synth.cal_valid    = s_q.cal_valid;
	assign synth.cal_done     = s_q.cal_done;
	assign pa.pa_index        = s_q.shp;
	assign pa.pa_setting      = s_q.pa_set;

	// ==========================================================
	// Next state
	always_comb begin
		s_d     = s_q;
		ra      = 8'(s_axi_araddr);
		cal_cmd = 1'b0;
		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_h = 1'b1;
			s_d.awa  = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_h = 1'b1;
			s_d.wd  = s_axi_wdata[7:0];
			s_d.wst = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		wr_go = s_q.aw_h && s_q.w_h && !s_q.bvalid;
		if (wr_go) begin
			s_d.aw_h   = 1'b0;
			s_d.w_h    = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = `SFPC_RESP_OKAY;
			// Only byte lane 0 carries register bits
			if (s_q.wst) begin
				case (s_q.awa)
					`SFPC_A_BASE_HI: s_d.f_hi = s_q.wd;
					`SFPC_A_BASE_MID: s_d.f_mid = s_q.wd;
					`SFPC_A_BASE_LO: s_d.f_lo = s_q.wd;
					`SFPC_A_HOP: s_d.hop_index = s_q.wd;
					`SFPC_A_MODEM_LO: s_d.spacing_mantissa = s_q.wd;
					`SFPC_A_MODEM_HI: s_d.spacing_exponent = s_q.wd[1:0];
					`SFPC_A_SYNTH1: s_d.if_tuning = s_q.wd[4:0];
					`SFPC_A_STATE0: s_d.acal = s_q.wd[5:4];
					`SFPC_A_FRONT0: s_d.top = s_q.wd[2:0];
					`SFPC_A_CMD: cal_cmd = s_q.wd[`SFPC_CMD_CAL_BIT];
					`SFPC_A_STATUS, `SFPC_A_CARRIER: begin
					end
					default: begin
						if (s_q.awa[7:5] == `SFPC_PTAB_HI3 && s_q.awa[1:0] == 2'b00) begin
							s_d.ptab[s_q.awa[4:2]] = s_q.wd;
						end else begin
							s_d.bresp = `SFPC_RESP_SLVERR;
						end
					end
				endcase
			end
		end
		// Read channel: one read in flight, answered next cycle
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = `SFPC_RESP_OKAY;
			s_d.rdata  = 32'h0000_0000;
			case (ra)
				`SFPC_A_BASE_HI: s_d.rdata[7:0] = s_q.f_hi;
				`SFPC_A_BASE_MID: s_d.rdata[7:0] = s_q.f_mid;
				`SFPC_A_BASE_LO: s_d.rdata[7:0] = s_q.f_lo;
				`SFPC_A_HOP: s_d.rdata[7:0] = s_q.hop_index;
				`SFPC_A_MODEM_LO: s_d.rdata[7:0] = s_q.spacing_mantissa;
				`SFPC_A_MODEM_HI: s_d.rdata[1:0] = s_q.spacing_exponent;
				`SFPC_A_SYNTH1: s_d.rdata[4:0] = s_q.if_tuning;
				`SFPC_A_STATE0: s_d.rdata[5:4] = s_q.acal;
				`SFPC_A_FRONT0: s_d.rdata[2:0] = s_q.top;
				`SFPC_A_CMD: begin
				end
				`SFPC_A_STATUS: s_d.rdata[5:0] = {s_q.shp, 1'b0, s_q.cal_valid,
					s_q.cal == CAL_RUN};
				`SFPC_A_CARRIER: s_d.rdata[26:0] = s_q.carrier;
				default: begin
					if (ra[7:5] == `SFPC_PTAB_HI3 && ra[1:0] == 2'b00) begin
						s_d.rdata[7:0] = s_q.ptab[ra[4:2]];
					end else begin
						s_d.rresp = `SFPC_RESP_SLVERR;
					end
				end
			endcase
		end
		// Calibration; triggers while running are dropped
		s_d.synth_on = radio.synth_on;
		s_d.cal_done = 1'b0;
		son_rise  = radio.synth_on && !s_q.synth_on;
		son_fall  = !radio.synth_on && s_q.synth_on;
		auto_trig = (s_q.acal == `SFPC_ACAL_ON && son_rise) ||
			(s_q.acal == `SFPC_ACAL_OFF && son_fall);
		man_trig  = cal_cmd && radio.radio_idle;
		case (s_q.cal)
			CAL_IDLE: begin
				if (auto_trig || man_trig) begin
					s_d.cal     = CAL_RUN;
					s_d.cal_cnt = CAL_LAST;
				end
			end
			CAL_RUN: begin
				if (s_q.cal_cnt == '0) begin
					s_d.cal       = CAL_IDLE;
					s_d.cal_done  = 1'b1;
					s_d.cal_valid = 1'b1;
				end else begin
					s_d.cal_cnt = s_q.cal_cnt - 1'b1;
				end
			end
			default: s_d.cal = CAL_IDLE;
		endcase
		// Shaping counter; ramp and keying share one path
		up = radio.tx_active && (radio.ask_mode ? radio.ask_bit : 1'b1);
		if (radio.shape_tick) begin
			if (up && s_q.shp < s_q.top) begin
				s_d.shp = s_q.shp + 1'b1;
			end else if (up) begin
				s_d.shp = s_q.top;
			end else if (s_q.shp != 3'h0) begin
				s_d.shp = s_q.shp - 1'b1;
			end
		end
		s_d.pa_set  = s_q.ptab[s_q.shp];
		s_d.carrier = calc_carrier({s_q.f_hi, s_q.f_mid, s_q.f_lo}, s_q.hop_index,
			s_q.spacing_mantissa, s_q.spacing_exponent);
	end

	// ==========================================================
	// State register; rst_b loads the reset values and clears calibration results
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q                  <= '0;
			s_q.f_hi             <= `SFPC_RST_BYTE;
			s_q.spacing_exponent <= `SFPC_RST_EXP;
			s_q.if_tuning        <= `SFPC_RST_IF;
			s_q.acal             <= `SFPC_RST_ACAL;
			s_q.top              <= `SFPC_RST_TOP;
			s_q.ptab             <= {8{`SFPC_RST_PTAB}};
			s_q.cal              <= CAL_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic [`SFPC_CAL_CNT_W:0] busy_len;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_len <= '0;
		end else begin
			busy_len <= synth.cal_busy ? busy_len + 1'b1 : '0;
		end
	end

	sequence man_req;
		cal_cmd && radio.radio_idle && s_q.acal == `SFPC_ACAL_MANUAL && !synth.cal_busy;
	endsequence
	sequence auto_on_req;
		s_q.acal == `SFPC_ACAL_ON && radio.synth_on && !s_q.synth_on && !synth.cal_busy;
	endsequence
	sequence auto_off_req;
		s_q.acal == `SFPC_ACAL_OFF && !radio.synth_on && s_q.synth_on && !synth.cal_busy;
	endsequence
	sequence cal_finish;
		!synth.cal_busy && synth.cal_done && synth.cal_valid;
	endsequence

	// Busy length counted in helper logic; too long for a repetition
	cal_length_a: assert property (
		$fell(synth.cal_busy) |-> busy_len == (`SFPC_CAL_CNT_W+1)'(CAL_CYCLES))
		else $error("calibration length wrong");
	cal_done_a: assert property (
		$fell(synth.cal_busy) |-> cal_finish)
		else $error("calibration end not flagged");
	manual_start_a: assert property (
		man_req |=> synth.cal_busy ##0 !$past(synth.cal_busy))
		else $error("strobe did not start calibration");
	idle_gate_a: assert property (
		cal_cmd && !radio.radio_idle && !auto_trig && !synth.cal_busy |=> !synth.cal_busy)
		else $error("strobe outside idle started calibration");
	auto_on_a: assert property (
		auto_on_req |=> synth.cal_busy)
		else $error("switch-on did not calibrate");
	auto_off_a: assert property (
		auto_off_req |=> synth.cal_busy)
		else $error("switch-off did not calibrate");
	cal_kept_a: assert property (
		synth.cal_done |-> synth.cal_valid ##1 synth.cal_valid)
		else $error("calibration valid lost");
	if_load_a: assert property (
		wr_go && s_q.wst && s_q.awa == `SFPC_A_SYNTH1 |=> synth.if_word == $past(s_q.wd[4:0]))
		else $error("intermediate word not loaded");
	ptab_write_a: assert property (
		wr_go && s_q.wst && s_q.awa[7:5] == `SFPC_PTAB_HI3 && s_q.awa[1:0] == 2'b00
		|=> s_q.ptab[$past(s_q.awa[4:2])] == $past(s_q.wd))
		else $error("power table write lost");
	pa_zero_a: assert property (
		s_q.top == 3'h0 && $past(s_q.top) == 3'h0 && pa.pa_index == 3'h0
		|=> pa.pa_index == 3'h0)
		else $error("ramp with index zero");
	shape_step_a: assert property (
		radio.shape_tick && up && pa.pa_index < s_q.top
		|=> pa.pa_index == $past(pa.pa_index) + 3'h1)
		else $error("shaping step missing");
	ramp_down_a: assert property (
		radio.shape_tick && !up && pa.pa_index != 3'h0
		|=> pa.pa_index == $past(pa.pa_index) - 3'h1)
		else $error("ramp down step missing");
	shape_cap_a: assert property (
		radio.shape_tick && up |=> pa.pa_index <= $past(s_q.top))
		else $error("shaping above top index");
	shape_sat_a: assert property (
		radio.shape_tick && !up && pa.pa_index == 3'h0
		|=> pa.pa_index == 3'h0)
		else $error("shaping underflow");
	pa_lookup_a: assert property (
		1'b1 |=> pa.pa_setting == $past(s_q.ptab[pa.pa_index]))
		else $error("table lookup mismatch");
	// Every operand widened first so no product is cut short
	carrier_a: assert property (
		1'b1 |=> synth.carrier_word == 27'($past({s_q.f_hi, s_q.f_mid, s_q.f_lo})) * 27'h4
		+ 27'($past(s_q.hop_index)) * 27'h400
		+ ((27'($past(s_q.hop_index)) * 27'($past(s_q.spacing_mantissa)))
		<< $past(s_q.spacing_exponent)))
		else $error("carrier word wrong");
endmodule : sfpc_ctrl

// ===== sim/sfpc_mcu.sv
// Microcontroller model: AXI4-Lite master on the register port.
// Assumes one clock; bready and rready are held high throughout.
module sfpc_mcu import sfpc_pkg::*; (
	input  wire logic        sys_clk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Idle bus
	initial begin
		{awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
		wstrb  = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
	end
	// ==========================================================
	// Transfers; released payload shows its inverse, not a stale value
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
		end while (!bvalid);
		r = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd
endmodule : sfpc_mcu

// ===== sim/tb_top.sv
// Testbench: register, calibration and power shaping tests by bus calls.
// Assumes the design package and sfpc_params.svh are compiled first.
`include "sfpc_params.svh"
module tb_top import sfpc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// Short calibration keeps the run brief
	localparam int CAL = 20;
	logic        sys_clk, rst_b;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	sfpc_radio_s radio;
	sfpc_synth_s synth;
	sfpc_pa_s    pa;
	logic [2:0]  idx;
	int          mismatches, num_checks, n;
	sfpc_ctrl #(.CAL_CYCLES(CAL)) uut (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.radio, .synth, .pa);
	sfpc_mcu mcu (.sys_clk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
		.awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
		.rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		mcu.wr(a, d, resp);
	endtask : w
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		mcu.rd(a, rd_v, resp);
		chk(rd_v, e);
	endtask : rc
	task automatic cal_len(output int c);
		c = 0;
		for (int k = 0; k < 200; k++) begin
			@(posedge sys_clk);
			if (synth.cal_busy === 1'b1) c++;
			else if (c > 0) break;
		end
		chk(32'(synth.cal_done), 32'h0000_0001);
	endtask : cal_len
	// Up flag passed in: radio fields set just before are not landed yet
	task automatic ticks(input int cnt, input logic [2:0] top, input logic up);
		for (int k = 0; k < cnt; k++) begin
			idx = up ? ((idx < top) ? idx + 3'd1 : top) : ((idx != 3'd0) ? idx - 3'd1 : 3'd0);
			radio.shape_tick <= 1'b1;
			@(posedge sys_clk);
			radio.shape_tick <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk(32'(pa.pa_index), 32'(idx));
			chk(32'(pa.pa_setting), 32'h0000_0030 + 32'(idx));
		end
	endtask : ticks
	task automatic wrap_up;
		if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// Tests
	initial begin
		rst_b = 1'b0;
		radio = '0;
		radio.radio_idle = 1'b1;
		idx = 3'd0;
		mismatches = 0;
		num_checks = 0;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rc(8'h40, 32'h0000_00C6);
		rc(8'h5C, 32'h0000_00C6);
		chk(32'(pa.pa_setting), 32'h0000_00C6);
		chk(32'(synth.if_word), 32'h0000_000F);
		w(`SFPC_A_BASE_HI, 32'h0000_0010);
		chk(32'(resp), 32'(`SFPC_RESP_OKAY));
		w(`SFPC_A_BASE_MID, 32'h0000_00A7);
		w(`SFPC_A_BASE_LO, 32'h0000_0062);
		w(`SFPC_A_HOP, 32'h0000_00FF);
		w(`SFPC_A_MODEM_LO, 32'h0000_00F8);
		for (int e = 0; e < 4; e++) begin
			w(`SFPC_A_MODEM_HI, 32'(e));
			rc(`SFPC_A_CARRIER, 32'h0042_9D88 + 32'd255 * (32'd1024 + (32'h00F8 << e)));
		end
		chk(32'(synth.carrier_word), 32'h0042_9D88 + 32'd255 * 32'd3008);
		w(`SFPC_A_SYNTH1, 32'hFFFF_FF13);
		chk(32'(synth.if_word), 32'h0000_0013);
		fork
			w(`SFPC_A_CMD, 32'h0000_0001);
			cal_len(n);
		join
		chk(32'(n), 32'(CAL));
		rc(`SFPC_A_STATUS, 32'h0000_0002);
		chk(32'(synth.cal_valid), 32'h0000_0001);
		radio.radio_idle <= 1'b0;
		w(`SFPC_A_CMD, 32'h0000_0001);
		repeat (3) @(posedge sys_clk);
		chk(32'(synth.cal_busy), 32'h0000_0000);
		radio.radio_idle <= 1'b1;
		radio.synth_on <= 1'b1;
		cal_len(n);
		chk(32'(n), 32'(CAL));
		w(`SFPC_A_STATE0, 32'h0000_0020);
		radio.synth_on <= 1'b0;
		cal_len(n);
		chk(32'(n), 32'(CAL));
		// Manual mode: synth edges alone must not calibrate
		w(`SFPC_A_STATE0, 32'h0000_0000);
		radio.synth_on <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(32'(synth.cal_busy), 32'h0000_0000);
		radio.synth_on <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(32'(synth.cal_busy), 32'h0000_0000);
		fork
			w(`SFPC_A_CMD, 32'h0000_0001);
			cal_len(n);
		join
		chk(32'(n), 32'(CAL));
		for (int i = 0; i < 8; i++) w(8'h40 + 8'(4 * i), 32'h0000_0030 + 32'(i));
		rc(8'h4C, 32'h0000_0033);
		w(`SFPC_A_FRONT0, 32'h0000_0003);
		radio.tx_active <= 1'b1;
		ticks(5, 3'd3, 1'b1);
		radio.tx_active <= 1'b0;
		ticks(4, 3'd3, 1'b0);
		w(`SFPC_A_FRONT0, 32'h0000_0007);
		radio.ask_mode <= 1'b1;
		radio.tx_active <= 1'b1;
		radio.ask_bit <= 1'b1;
		ticks(9, 3'd7, 1'b1);
		radio.ask_bit <= 1'b0;
		ticks(5, 3'd7, 1'b0);
		w(`SFPC_A_FRONT0, 32'h0000_0000);
		radio.ask_mode <= 1'b0;
		ticks(2, 3'd0, 1'b1);
		mcu.rd(8'h30, rd_v, resp);
		chk(32'(resp), 32'(`SFPC_RESP_SLVERR));
		chk(rd_v, 32'h0000_0000);
		mcu.wr(8'h30, 32'h0000_00FF, resp);
		chk(32'(resp), 32'(`SFPC_RESP_SLVERR));
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		wrap_up();
	end
endmodule : tb_top
